// ---- crs_map.svh ----
/*
 * register layout constants for the cpu status and register set:
 * program status field positions, reset values, direct window limits.
 * assumes inclusion by the design package user; definitions only.
 */
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

// ****************************************
// program status word layout
// ****************************************
`define CRS_PSW_C_BIT       0
`define CRS_PSW_V_BIT       1
`define CRS_PSW_Z_BIT       2
`define CRS_PSW_N_BIT       3
`define CRS_PSW_I_BIT       4
`define CRS_PSW_S_BIT       5
`define CRS_PSW_T_BIT       8
`define CRS_PSW_ILM_LSB     16
`define CRS_PSW_ILM_MSB     20
`define CRS_PSW_WMASK       32'h001f_013f

// ****************************************
// reset values
// ****************************************
`define CRS_PSW_RESET       32'h000f_0000
`define CRS_SSP_RESET       32'h0000_0000
`define CRS_ZERO32          32'h0000_0000

// ****************************************
// direct addressing window limits
// ****************************************
`define CRS_DIR_BYTE_MAX    32'h0000_00ff
`define CRS_DIR_HALF_MAX    32'h0000_01ff
`define CRS_DIR_WORD_MAX    32'h0000_03ff

// ****************************************
// reset hold time
// ****************************************
`define CRS_RST_HOLD_CYC    5

`endif

// ---- crs_pkg.sv ----
/*
 * types for the cpu status and register set.
 * assumes crs_map.svh for numeric constants.
 */
package crs_pkg;

  typedef enum logic [1:0] {
    crs_size_byte = 2'h0,
    crs_size_half = 2'h1,
    crs_size_word = 2'h2
  } crs_size_t;

  typedef enum logic [2:0] {
    crs_flag_keep  = 3'h0,
    crs_flag_alu   = 3'h1,
    crs_flag_div   = 3'h2,
    crs_flag_write = 3'h4
  } crs_flag_op_t;

endpackage

// ---- crs_core_regs.sv ----
/*
 * cpu architectural state: sixteen general registers, dedicated registers,
 * program status word with interrupt level masking, direct window check.
 * assumes a pipeline on the same clock drives the write ports and an
 * interrupt source presents one request level at a time.
 */
`timescale 1ns/1ps
`include "crs_map.svh"

module crs_core_regs
  import crs_pkg::*;
#(
  parameter int NUM_GPR = 16
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // general register read ports
  input  wire logic [3:0]   gpr_raddr_a,
  output logic      [31:0]  gpr_rdata_a,
  input  wire logic [3:0]   gpr_raddr_b,
  output logic      [31:0]  gpr_rdata_b,
  // general register write port
  input  wire logic         gpr_we,
  input  wire logic [3:0]   gpr_waddr,
  input  wire logic [31:0]  gpr_wdata,
  // instruction pointer
  input  wire logic         instr_pointer_we,
  input  wire logic [31:0]  instr_pointer_wdata,
  output logic      [31:0]  instr_pointer,
  // dedicated registers
  input  wire logic         vector_table_base_we,
  input  wire logic [31:0]  vector_table_base_wdata,
  output logic      [31:0]  vector_table_base,
  input  wire logic         return_address_reg_we,
  input  wire logic [31:0]  return_address_reg_wdata,
  output logic      [31:0]  return_address_reg,
  input  wire logic         system_stack_ptr_we,
  input  wire logic [31:0]  system_stack_ptr_wdata,
  output logic      [31:0]  system_stack_ptr,
  input  wire logic         user_stack_ptr_we,
  input  wire logic [31:0]  user_stack_ptr_wdata,
  output logic      [31:0]  user_stack_ptr,
  // multiply and divide results
  input  wire logic         muldiv_we,
  input  wire logic [31:0]  muldiv_high_wdata,
  input  wire logic [31:0]  muldiv_low_wdata,
  output logic      [31:0]  muldiv_result_high,
  output logic      [31:0]  muldiv_result_low,
  // program status word and flag updates
  input  wire logic         psw_we,
  input  wire logic [31:0]  psw_wdata,
  input  wire crs_flag_op_t flag_op,
  input  wire logic [31:0]  alu_result,
  input  wire logic         alu_carry,
  input  wire logic         alu_overflow,
  output logic      [31:0]  program_status_word,
  output logic      [7:0]   condition_flags,
  output logic      [7:0]   system_condition_flags,
  output logic      [4:0]   interrupt_level_mask,
  output logic              trace_trap_enable,
  // interrupt request acceptance
  input  wire logic         irq_valid,
  input  wire logic [4:0]   irq_level,
  output logic              irq_accept,
  // direct addressing window check
  input  wire logic [31:0]  dir_addr,
  input  wire crs_size_t    dir_size,
  output logic              dir_in_window
);

  // ****************************************
  // storage
  // ****************************************
  logic [31:0] gpr [NUM_GPR-2:0];
  logic [31:0] psw;
  logic [31:0] next_psw;
  logic        stack_sel;

  // ****************************************
  // decode wires
  // ****************************************
  logic        res_negative;
  logic        res_zero;
  logic        op_alu;
  logic        op_div;
  logic        op_write;
  logic [31:0] write_value;
  logic        r15_write;
  logic        gpr_array_we;
  logic        ssp_from_r15;
  logic        usp_from_r15;
  logic        ssp_load;
  logic        usp_load;
  logic [31:0] next_system_stack_ptr;
  logic [31:0] next_user_stack_ptr;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] gpr_read(input logic [3:0] a);
    if (a == 4'hf) begin
      gpr_read = stack_sel ? user_stack_ptr : system_stack_ptr;
    end else begin
      gpr_read = gpr[a];
    end
  endfunction

  function automatic logic in_window(input logic [31:0] a, input crs_size_t s);
    case (s)
      crs_size_byte: in_window = (a <= `CRS_DIR_BYTE_MAX);
      crs_size_half: in_window = (a <= `CRS_DIR_HALF_MAX);
      crs_size_word: in_window = (a <= `CRS_DIR_WORD_MAX);
      default:       in_window = 1'b0;
    endcase
  endfunction

  // ****************************************
  // combinational views
  // ****************************************
  // sixteen registers, r15 special
  assign gpr_rdata_a = gpr_read(gpr_raddr_a);
  assign gpr_rdata_b = gpr_read(gpr_raddr_b);

  // full 32-bit linear address, no segment
  assign dir_in_window = in_window(dir_addr, dir_size);

  // status word split into its fields
  assign program_status_word    = psw;
  assign condition_flags        = psw[7:0];
  assign system_condition_flags = psw[15:8];
  assign interrupt_level_mask   = psw[`CRS_PSW_ILM_MSB:`CRS_PSW_ILM_LSB];
  assign stack_sel              = psw[`CRS_PSW_S_BIT];

  assign trace_trap_enable = psw[`CRS_PSW_T_BIT];

  // lower value means higher priority, so strictly smaller wins
  // equal or lower priority held off
  assign irq_accept = irq_valid && psw[`CRS_PSW_I_BIT]
                      && (irq_level < interrupt_level_mask);

  // ****************************************
  // flag sources
  // ****************************************
  // sign and zero of the result
  assign res_negative = alu_result[31];
  assign res_zero     = (alu_result == `CRS_ZERO32);

  // a whole-word write beats a simultaneous flag op
  assign op_write = psw_we || (flag_op == crs_flag_write);
  assign op_alu   = !psw_we && (flag_op == crs_flag_alu);
  assign op_div   = !psw_we && (flag_op == crs_flag_div);

  // unused bits read zero so software sees no stale junk
  assign write_value = psw_wdata & `CRS_PSW_WMASK;

  // ****************************************
  // flag update
  // ****************************************
  always_comb begin
    next_psw = psw;
    if (op_write) begin
      next_psw = write_value;
    end else if (op_alu) begin
      next_psw[`CRS_PSW_N_BIT] = res_negative;
      next_psw[`CRS_PSW_Z_BIT] = res_zero;
      next_psw[`CRS_PSW_V_BIT] = alu_overflow;
      // carry or borrow at top bit
      next_psw[`CRS_PSW_C_BIT] = alu_carry;
    end else if (op_div) begin
      // division touches sign and zero only
      next_psw[`CRS_PSW_N_BIT] = res_negative;
      next_psw[`CRS_PSW_Z_BIT] = res_zero;
    end
  end

  // ****************************************
  // register 15 routing
  // ****************************************
  // index 15 never lands in the array
  assign r15_write    = gpr_we && (gpr_waddr == 4'hf);
  assign gpr_array_we = gpr_we && (gpr_waddr != 4'hf);
  assign ssp_from_r15 = r15_write && !stack_sel;
  assign usp_from_r15 = r15_write && stack_sel;

  // r15 write wins over a direct load in the same cycle
  assign ssp_load = ssp_from_r15 || system_stack_ptr_we;
  assign usp_load = usp_from_r15 || user_stack_ptr_we;
  assign next_system_stack_ptr = ssp_from_r15 ? gpr_wdata : system_stack_ptr_wdata;
  assign next_user_stack_ptr   = usp_from_r15 ? gpr_wdata : user_stack_ptr_wdata;

  // ****************************************
  // registers
  // ****************************************
  // r0..r14 have no reset; undefined until written
  // no reset here keeps the array small; software must write first
  always_ff @(posedge mclk) begin
    if (gpr_array_we) begin
      gpr[gpr_waddr] <= gpr_wdata;
    end
  end

  // reset is synchronous; caller holds it low long enough
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      psw <= `CRS_PSW_RESET;
    end else begin
      psw <= next_psw;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      instr_pointer <= `CRS_ZERO32;
    end else if (instr_pointer_we) begin
      instr_pointer <= instr_pointer_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vector_table_base <= `CRS_ZERO32;
    end else if (vector_table_base_we) begin
      vector_table_base <= vector_table_base_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      return_address_reg <= `CRS_ZERO32;
    end else if (return_address_reg_we) begin
      return_address_reg <= return_address_reg_wdata;
    end
  end

  // result pair loads as one unit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      muldiv_result_high <= `CRS_ZERO32;
      muldiv_result_low  <= `CRS_ZERO32;
    end else if (muldiv_we) begin
      muldiv_result_high <= muldiv_high_wdata;
      muldiv_result_low  <= muldiv_low_wdata;
    end
  end

  // r15 reads zero after reset via the system pointer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      system_stack_ptr <= `CRS_SSP_RESET;
    end else if (ssp_load) begin
      system_stack_ptr <= next_system_stack_ptr;
    end
  end

  // user side of the stack pair
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      user_stack_ptr <= `CRS_ZERO32;
    end else if (usp_load) begin
      user_stack_ptr <= next_user_stack_ptr;
    end
  end

endmodule

// ---- crs_core_regs_assertions.sv ----
/* checker for crs_core_regs port relations.
   assumes bind onto crs_core_regs, one clock, sync reset. */
`timescale 1ns/1ps
`include "crs_map.svh"
module crs_core_regs_assertions
  import crs_pkg::*;
(
  // clock and reset
  input wire logic mclk, rst_n,
  // status word and flag sources
  input wire logic psw_we, alu_carry, alu_overflow,
  input wire logic [31:0] psw_wdata, alu_result, program_status_word,
  input wire crs_flag_op_t flag_op,
  // requests and window
  input wire logic irq_valid, irq_accept, dir_in_window,
  input wire logic [4:0] irq_level,
  input wire logic [31:0] dir_addr,
  input wire crs_size_t dir_size,
  // stacks and results
  input wire logic [3:0] gpr_raddr_a,
  input wire logic [31:0] gpr_rdata_a, system_stack_ptr, user_stack_ptr,
  input wire logic muldiv_we,
  input wire logic [31:0] muldiv_high_wdata, muldiv_low_wdata,
  input wire logic [31:0] muldiv_result_high, muldiv_result_low
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_alu; flag_op == crs_flag_alu && !psw_we; endsequence
  sequence s_div; flag_op == crs_flag_div && !psw_we; endsequence
  AST_PSW_RST: assert property ($rose(rst_n) |-> program_status_word == `CRS_PSW_RESET)
    else $error("status word reset value wrong");
  AST_PSW_WR: assert property (psw_we |=> program_status_word ==
    ($past(psw_wdata) & `CRS_PSW_WMASK)) else $error("status word write wrong");
  AST_ALU: assert property (s_alu |=> program_status_word[1:0] ==
    {$past(alu_overflow), $past(alu_carry)}) else $error("overflow or carry wrong");
  AST_DIV: assert property (s_div |=> program_status_word[3:2] ==
    {$past(alu_result[31]), $past(alu_result) == 32'h0} && $stable(program_status_word[1:0]))
    else $error("divide flags wrong");
  AST_IRQ: assert property (irq_accept == (irq_valid && program_status_word[4] &&
    irq_level < program_status_word[20:16])) else $error("request acceptance wrong");
  AST_WIN: assert property (dir_size != 2'h3 |-> dir_in_window ==
    (dir_addr <= (32'h100 << dir_size) - 32'h1)) else $error("direct window wrong");
  AST_R15: assert property (gpr_raddr_a == 4'hf |-> gpr_rdata_a ==
    (program_status_word[5] ? user_stack_ptr : system_stack_ptr)) else $error("r15 wrong");
  AST_MD: assert property (muldiv_we |=> {muldiv_result_high, muldiv_result_low} ==
    {$past(muldiv_high_wdata), $past(muldiv_low_wdata)}) else $error("result pair wrong");
endmodule
bind crs_core_regs crs_core_regs_assertions i_crs_core_regs_assertions (.*);

// ---- crs_irq_src.sv ----
/* interrupt request source model.
   assumes bench sets req and lvl just after a clock edge. */
`timescale 1ns/1ps
module crs_irq_src (
  input wire logic mclk, req,
  input wire logic [4:0] lvl,
  output logic irq_valid = 1'b0,
  output logic [4:0] irq_level = 5'h00
);
  // level 0 highest
  // idle level flips so a stale level never looks valid
  always @(posedge mclk) begin
    #1;
    irq_valid = req;
    irq_level = req ? lvl : ~irq_level;
  end
endmodule

// ---- cpu_status_and_register_set_bench.sv ----
/* self-checking bench for crs_core_regs.
   assumes crs_irq_src as request source, 40 MHz clock. */
`timescale 1ns/1ps
`include "crs_map.svh"
module cpu_status_and_register_set_bench
  import crs_pkg::*;
;
  logic mclk = 1'b0, rst_n = 1'b0, req = 1'b0, alu_carry = 1'b0, alu_overflow = 1'b0;
  logic gpr_we = 1'b0, instr_pointer_we = 1'b0, vector_table_base_we = 1'b0, psw_we = 1'b0;
  logic return_address_reg_we = 1'b0, system_stack_ptr_we = 1'b0, user_stack_ptr_we = 1'b0;
  logic muldiv_we = 1'b0, trace_trap_enable, irq_valid, irq_accept, dir_in_window;
  logic [3:0] gpr_raddr_a = 4'h0, gpr_raddr_b = 4'h0, gpr_waddr = 4'h0;
  logic [4:0] lvl = 5'h00, interrupt_level_mask, irq_level;
  logic [31:0] gpr_wdata = 32'h0, instr_pointer_wdata = 32'h0, vector_table_base_wdata = 32'h0;
  logic [31:0] return_address_reg_wdata = 32'h0, system_stack_ptr_wdata = 32'h0;
  logic [31:0] user_stack_ptr_wdata = 32'h0, muldiv_high_wdata = 32'h0, psw_wdata = 32'h0;
  logic [31:0] muldiv_low_wdata = 32'h0, alu_result = 32'h0, dir_addr = 32'h0;
  logic [31:0] gpr_rdata_a, gpr_rdata_b, instr_pointer, vector_table_base, return_address_reg;
  logic [31:0] system_stack_ptr, user_stack_ptr, muldiv_result_high, muldiv_result_low;
  logic [31:0] program_status_word;
  logic [7:0] condition_flags, system_condition_flags;
  crs_flag_op_t flag_op = crs_flag_keep;
  crs_size_t dir_size = crs_size_byte;
  int bad_count = 0, n_checks = 0;
  crs_core_regs i_crs_core_regs (.*);
  crs_irq_src i_crs_irq_src (.mclk, .req, .lvl, .irq_valid, .irq_level);
  // ****************
  // helpers
  // ****************
  initial forever #12.5 mclk = ~mclk;
  task step; @(posedge mclk); #2; endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task end_sim;
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wpsw(input logic [31:0] v); psw_we = 1'b1; psw_wdata = v; step; psw_we = 1'b0; endtask
  // ****************
  // scenarios
  // ****************
  // five low edges keep the reset duty
  task t_reset;
    rst_n = 1'b0; gpr_raddr_a = 4'hf; repeat (5) step; rst_n = 1'b1; step;
    chk("psw", 32'h000f_0000, program_status_word);
    chk("ilm", 32'h0f, {27'h0, interrupt_level_mask});
    chk("scr", 32'h0, {24'h0, system_condition_flags});
    chk("r15", 32'h0, gpr_rdata_a);
  endtask
  task t_gpr;
    gpr_we = 1'b1; gpr_waddr = 4'hd; gpr_wdata = 32'h1111_2222; step;
    gpr_waddr = 4'he; gpr_wdata = 32'h3333_4444; step;
    gpr_we = 1'b0; gpr_raddr_a = 4'hd; gpr_raddr_b = 4'he; step;
    chk("r13", 32'h1111_2222, gpr_rdata_a);
    chk("r14", 32'h3333_4444, gpr_rdata_b);
  endtask
  task t_stack;
    system_stack_ptr_we = 1'b1; system_stack_ptr_wdata = 32'h8000; gpr_raddr_a = 4'hf;
    user_stack_ptr_we = 1'b1; user_stack_ptr_wdata = 32'h4000; step;
    system_stack_ptr_we = 1'b0; user_stack_ptr_we = 1'b0; step;
    chk("r15 sys", 32'h8000, gpr_rdata_a);
    wpsw(32'h0000_0020);
    chk("r15 usr", 32'h4000, gpr_rdata_a);
    gpr_we = 1'b1; gpr_waddr = 4'hf; gpr_wdata = 32'h5000; step; gpr_we = 1'b0;
    chk("usp", 32'h5000, user_stack_ptr);
    chk("ssp", 32'h8000, system_stack_ptr);
  endtask
  task t_flags;
    flag_op = crs_flag_alu; alu_carry = 1'b1; alu_overflow = 1'b1; step;
    chk("flags alu", 32'h27, {24'h0, condition_flags});
    flag_op = crs_flag_div; alu_result = 32'h8000_0000; alu_carry = 1'b0; step;
    flag_op = crs_flag_keep;
    chk("flags div", 32'h2b, {24'h0, condition_flags});
    flag_op = crs_flag_write; psw_wdata = 32'h0000_0021; step; flag_op = crs_flag_keep;
    chk("flag write", 32'h21, program_status_word);
    flag_op = crs_flag_alu; alu_carry = 1'b0; wpsw(32'h0000_0020); flag_op = crs_flag_keep;
    chk("psw over alu", 32'h20, program_status_word);
  endtask
  task t_ded;
    instr_pointer_we = 1'b1; instr_pointer_wdata = 32'hfffe_0000;
    vector_table_base_we = 1'b1; vector_table_base_wdata = 32'h000f_fc00;
    return_address_reg_we = 1'b1; return_address_reg_wdata = 32'h1234_5678;
    muldiv_we = 1'b1; muldiv_high_wdata = 32'hdead_0001; muldiv_low_wdata = 32'h0bad_0002; step;
    {instr_pointer_we, vector_table_base_we, return_address_reg_we, muldiv_we} = 4'h0;
    chk("ip", 32'hfffe_0000, instr_pointer);
    chk("tbr", 32'h000f_fc00, vector_table_base);
    chk("ret", 32'h1234_5678, return_address_reg);
    chk("mdh", 32'hdead_0001, muldiv_result_high);
    chk("mdl", 32'h0bad_0002, muldiv_result_low);
    wpsw(32'h0000_0100);
    chk("trace", 32'h1, {31'h0, trace_trap_enable});
    chk("scr trace", 32'h1, {24'h0, system_condition_flags});
    wpsw(32'hffff_ffff);
    chk("psw mask", `CRS_PSW_WMASK, program_status_word);
  endtask
  task t_irq;
    logic [4:0] lv [4];
    lv = '{5'h00, 5'h0e, 5'h0f, 5'h1f};
    wpsw(32'h000f_0010);
    for (int i = 0; i < 4; i++) begin
      req = 1'b1; lvl = lv[i]; step; step;
      chk("accept", {31'h0, i < 2}, {31'h0, irq_accept});
    end
    lvl = 5'h00; step; wpsw(32'h000f_0000);
    chk("accept off", 32'h0, {31'h0, irq_accept});
    wpsw(32'h0000_0010);
    chk("accept ilm0", 32'h0, {31'h0, irq_accept});
    req = 1'b0; step;
  endtask
  task t_win;
    for (int i = 0; i < 3; i++) begin
      dir_size = crs_size_t'(i); dir_addr = (32'h100 << i) - 32'h1; step;
      chk("win top", 32'h1, {31'h0, dir_in_window});
      dir_addr = 32'h100 << i; step;
      chk("win out", 32'h0, {31'h0, dir_in_window});
    end
  endtask
  initial begin
    #20000;
    bad_count++;
    end_sim;
  end
  initial begin
    t_reset; t_gpr; t_stack; t_flags; t_ded; t_irq; t_win; t_reset;
    end_sim;
  end
endmodule
